// [hdl/dtmf_port_pkg.sv]
// shared constants, field layouts and carriers of the tone transceiver port
package dtmf_port_pkg;

    // =========================================================
    // register selection
    localparam logic REG_DATA = 1'b0; // transmit / receive data
    localparam logic REG_CTRL = 1'b1; // control / status

    // =========================================================
    // status bit positions
    localparam int STAT_IRQ = 0; // interrupt pending
    localparam int STAT_TX_READY = 1; // transmitter ready
    localparam int STAT_RX_VALID = 2; // receive data valid
    localparam int STAT_STEER_N = 3; // delayed steering, active low

    // =========================================================
    // reset values
    localparam logic [3:0] CTRL_A_RESET = 4'h0;
    localparam logic [3:0] CTRL_B_RESET = 4'h0;
    localparam logic [3:0] TONE_CODE_RESET = 4'h0;

    // =========================================================
    // timing
    localparam int CLK_HZ = 125_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int BURST_DTMF_MS = 51; // nominal burst/pause
    localparam int BURST_CP_MS = 102; // call progress burst/pause
    localparam int BURST_DTMF_CYC = BURST_DTMF_MS * CYC_PER_MS;
    localparam int BURST_CP_CYC = BURST_CP_MS * CYC_PER_MS;
    localparam int GUARD_PRESENT_MS = 40; // tone present guard
    localparam int GUARD_ABSENT_MS = 40; // tone absent guard
    localparam int GUARD_PRESENT_CYC = GUARD_PRESENT_MS * CYC_PER_MS;
    localparam int GUARD_ABSENT_CYC = GUARD_ABSENT_MS * CYC_PER_MS;
    localparam int TIMER_W = 24; // wide enough for 102 ms

    // =========================================================
    // carriers
    typedef struct packed {
        logic redirect; // b3 next control write goes to b
        logic irq_en; // b2 interrupt enable
        logic mode_cp; // b1 call progress when set
        logic tone_en; // b0 tone output enable
    } ctrl_a_s;

    typedef struct packed {
        logic column_sel; // b3 column (high) group when set
        logic single; // b2 single tone when set
        logic test; // b1 test mode
        logic burst_off; // b0 burst timing off when set
    } ctrl_b_s;

    typedef struct packed {
        logic tone_on; // generator active
        logic single; // one tone only
        logic column_sel; // which group in single mode
        logic [3:0] code; // tone pair code
    } tone_drive_s;

endpackage : dtmf_port_pkg

// [hdl/dtmf_transceiver_host_port.sv]
// host register port, burst timer and receive steering of the transceiver
`timescale 1ns/100ps
module dtmf_transceiver_host_port
    import dtmf_port_pkg::*;
#(
    parameter int BURST_DTMF_CYCLES = BURST_DTMF_CYC,
    parameter int BURST_CP_CYCLES = BURST_CP_CYC,
    parameter int GUARD_PRESENT_CYCLES = GUARD_PRESENT_CYC,
    parameter int GUARD_ABSENT_CYCLES = GUARD_ABSENT_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    // host bus pins
    input wire logic bus_cs_n,
    input wire logic bus_strobe,
    input wire logic bus_read,
    input wire logic register_select_line,
    input wire logic [3:0] bus_data_in,
    output logic [3:0] bus_data_out,
    output logic bus_data_oe,
    // receiver front end
    input wire logic early_steer_out,
    input wire logic [3:0] detect_code,
    input wire logic cp_tone_in,
    output logic steer_guard_pin,
    // interrupt / call progress open-drain pin
    output logic request_progress_pin_out,
    output logic request_progress_pin_oe,
    // tone generator drive
    output tone_drive_s tone_drive
);

    // =========================================================
    // reset release
    logic [1:0] rst_pipe; // reset synchroniser
    logic rst_n; // synchronised reset

    // two flops release the reset cleanly
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // =========================================================
    // input synchronisers
    localparam int SYNC_W = 14; // bundled pin count
    logic [SYNC_W-1:0] pins_raw; // raw pin bundle
    logic [SYNC_W-1:0] sync_a; // first stage, read by sync_b only
    logic [SYNC_W-1:0] sync_b; // second stage

    assign pins_raw = {bus_cs_n, bus_strobe, bus_read,
                       register_select_line, bus_data_in,
                       early_steer_out, detect_code, cp_tone_in};

    // all outside pins cross through two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
        end
    end

    logic cs_n_s; // chip select
    logic strobe_s; // access strobe
    logic read_s; // read cycle
    logic control_b_redirect_s; // register select
    logic [3:0] din_s; // write data
    logic est_s; // early steering from detector
    logic [3:0] code_s; // detector code
    logic cp_s; // call progress comparator

    assign cs_n_s = sync_b[13];
    assign strobe_s = sync_b[12];
    assign read_s = sync_b[11];
    assign control_b_redirect_s = sync_b[10];
    assign din_s = sync_b[9:6];
    assign est_s = sync_b[5];
    assign code_s = sync_b[4:1];
    assign cp_s = sync_b[0];

    // =========================================================
    // bus cycle decode
    logic strobe_d; // strobe one cycle ago
    logic access_end; // strobe fell on a selected cycle
    logic wr_tx; // transmit data write
    logic wr_ctrl; // control write
    logic rd_status; // status read completed

    // remember strobe to find its falling edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strobe_d <= 1'b0;
        end else begin
            strobe_d <= strobe_s;
        end
    end

    // act once at the end of each selected access
    assign access_end = strobe_d && !strobe_s && !cs_n_s;
    assign wr_tx = access_end && !read_s && control_b_redirect_s == REG_DATA;
    assign wr_ctrl = access_end && !read_s && control_b_redirect_s == REG_CTRL;
    assign rd_status = access_end && read_s && control_b_redirect_s == REG_CTRL;

    // =========================================================
    // control registers
    ctrl_a_s ctrl_a; // control word a
    ctrl_b_s ctrl_b; // control word b
    logic to_b; // next control write lands in b
    logic [3:0] tone_code; // transmit data

    // control writes, redirect serves one write only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_a <= ctrl_a_s'(CTRL_A_RESET);
            ctrl_b <= ctrl_b_s'(CTRL_B_RESET);
            to_b <= 1'b0;
        end else if (wr_ctrl) begin
            if (to_b) begin
                ctrl_b <= ctrl_b_s'(din_s);
                to_b <= 1'b0;
            end else begin
                ctrl_a <= ctrl_a_s'(din_s);
                to_b <= din_s[3];
            end
        end
    end

    // transmit data is write-only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tone_code <= TONE_CODE_RESET;
        end else if (wr_tx) begin
            tone_code <= din_s;
        end
    end

    logic burst_mode; // burst timing selected
    assign burst_mode = !ctrl_b.burst_off;

    // =========================================================
    // burst and pause timer
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_BURST,
        TX_PAUSE
    } tx_state_e;

    tx_state_e tx_state; // burst sequencer
    logic [TIMER_W-1:0] tx_cnt; // interval counter
    logic [TIMER_W-1:0] tx_last; // last count of interval
    logic tx_done; // pause just ended

    // length doubles in call progress mode
    assign tx_last = ctrl_a.mode_cp ?
        TIMER_W'(BURST_CP_CYCLES - 1) :
        TIMER_W'(BURST_DTMF_CYCLES - 1);

    // counter held at zero when idle, burst starts at the write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE;
            tx_cnt <= '0;
        end else if (!burst_mode) begin
            tx_state <= TX_IDLE;
            tx_cnt <= '0;
        end else if (wr_tx) begin
            tx_state <= TX_BURST;
            tx_cnt <= '0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_cnt <= '0;
                end
                TX_BURST: begin
                    if (tx_cnt == tx_last) begin
                        tx_state <= TX_PAUSE;
                        tx_cnt <= '0;
                    end else begin
                        tx_cnt <= tx_cnt + 1'b1;
                    end
                end
                TX_PAUSE: begin
                    if (tx_cnt == tx_last) begin
                        tx_state <= TX_IDLE;
                        tx_cnt <= '0;
                    end else begin
                        tx_cnt <= tx_cnt + 1'b1;
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                    tx_cnt <= '0;
                end
            endcase
        end
    end

    assign tx_done = burst_mode && !wr_tx && tx_state == TX_PAUSE &&
                     tx_cnt == tx_last;

    // =========================================================
    // tone generator drive
    // burst gates the tone, otherwise the host gates it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tone_drive <= '0;
        end else begin
            tone_drive.code <= tone_code;
            tone_drive.single <= ctrl_b.single;
            tone_drive.column_sel <= ctrl_b.column_sel;
            if (burst_mode) begin
                tone_drive.tone_on <= ctrl_a.tone_en &&
                                      tx_state == TX_BURST;
            end else begin
                tone_drive.tone_on <= ctrl_a.tone_en;
            end
        end
    end

    // =========================================================
    // receive steering with guard times
    logic steer; // delayed steering, high while valid
    logic [TIMER_W-1:0] guard_cnt; // guard time counter
    logic [TIMER_W-1:0] guard_last; // guard length in use
    logic steer_rise; // valid tone accepted

    assign guard_last = steer ?
        TIMER_W'(GUARD_ABSENT_CYCLES - 1) :
        TIMER_W'(GUARD_PRESENT_CYCLES - 1);

    // steering follows early steering only after a full guard time
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            steer <= 1'b0;
            guard_cnt <= '0;
        end else if (est_s == steer) begin
            guard_cnt <= '0;
        end else if (guard_cnt == guard_last) begin
            steer <= est_s;
            guard_cnt <= '0;
        end else begin
            guard_cnt <= guard_cnt + 1'b1;
        end
    end

    assign steer_rise = est_s && !steer && guard_cnt == guard_last;
    assign steer_guard_pin = steer;

    // =========================================================
    // receive data register
    logic [3:0] rx_code; // last decoded code
    logic rx_latch; // decode this tone

    // call progress mode blocks decoding
    assign rx_latch = steer_rise && !ctrl_a.mode_cp;

    // code held until the next accepted tone
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_code <= 4'h0;
        end else if (rx_latch) begin
            rx_code <= code_s;
        end
    end

    // =========================================================
    // status flags, set wins over clear
    logic rx_valid; // receive data valid
    logic tx_ready; // transmitter ready
    logic irq_pend; // interrupt pending
    logic irq_set; // interrupt cause this cycle

    // receive valid cleared by status read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_valid <= 1'b0;
        end else if (rx_latch) begin
            rx_valid <= 1'b1;
        end else if (rd_status) begin
            rx_valid <= 1'b0;
        end
    end

    // transmit ready set after pause, cleared by read or write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_ready <= 1'b0;
        end else if (tx_done) begin
            tx_ready <= 1'b1;
        end else if (rd_status || wr_tx) begin
            tx_ready <= 1'b0;
        end
    end

    // interrupt causes: new data, or ready in burst timing
    assign irq_set = ctrl_a.irq_en && !ctrl_a.mode_cp &&
                     (rx_latch || tx_done);

    // pending interrupt cleared by status read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_pend <= 1'b0;
        end else if (irq_set) begin
            irq_pend <= 1'b1;
        end else if (rd_status) begin
            irq_pend <= 1'b0;
        end
    end

    // =========================================================
    // read data path
    logic [3:0] status_word; // status as read

    always_comb begin
        status_word = 4'h0;
        status_word[STAT_IRQ] = irq_pend;
        status_word[STAT_TX_READY] = tx_ready;
        status_word[STAT_RX_VALID] = rx_valid;
        status_word[STAT_STEER_N] = !steer;
    end

    // data bus driven while a selected read strobe is high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_data_out <= 4'h0;
            bus_data_oe <= 1'b0;
        end else begin
            bus_data_oe <= strobe_s && !cs_n_s && read_s;
            if (control_b_redirect_s == REG_CTRL) begin
                bus_data_out <= status_word;
            end else begin
                bus_data_out <= rx_code;
            end
        end
    end

    // =========================================================
    // open-drain interrupt / call progress pin
    logic pull_low; // pin pulled low

    always_comb begin
        if (ctrl_a.mode_cp) begin
            pull_low = ctrl_a.irq_en && !cp_s;
        end else if (ctrl_b.test) begin
            pull_low = steer; // inverted steering
        end else begin
            pull_low = ctrl_a.irq_en && irq_pend;
        end
    end

    // registered so the pin never glitches
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            request_progress_pin_oe <= 1'b0;
        end else begin
            request_progress_pin_oe <= pull_low;
        end
    end
    assign request_progress_pin_out = 1'b0;

endmodule : dtmf_transceiver_host_port // dtmf_transceiver_host_port

// [dv/dtmf_port_monitor.sv]
// assertion checker watching the host port pins
`timescale 1ns/100ps
module dtmf_port_monitor
    import dtmf_port_pkg::*;
#(
    parameter int GUARD_PRESENT_CYCLES = GUARD_PRESENT_CYC,
    parameter int GUARD_ABSENT_CYCLES = GUARD_ABSENT_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic bus_cs_n,
    input wire logic bus_strobe,
    input wire logic bus_read,
    input wire logic register_select_line,
    input wire logic [3:0] bus_data_out,
    input wire logic bus_data_oe,
    input wire logic early_steer_out,
    input wire logic steer_guard_pin,
    input wire logic request_progress_pin_out,
    input wire tone_drive_s tone_drive
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    // ==========
    // run lengths of the early steering input
    logic [23:0] hi_cnt; // cycles held high
    logic [23:0] lo_cnt; // cycles held low
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt <= '0;
            lo_cnt <= '0;
        end else begin
            hi_cnt <= early_steer_out ? hi_cnt + 24'h1 : '0;
            lo_cnt <= early_steer_out ? '0 : lo_cnt + 24'h1;
        end
    end
    // ==========
    // properties
    sequence s_strobe_fall;
        $fell(bus_strobe) && !bus_cs_n;
    endsequence
    property p_oe_cause;
        $rose(bus_data_oe) |-> $past(bus_strobe, 3) && $past(bus_read, 3)
            && !$past(bus_cs_n, 3);
    endproperty
    property p_oe_release;
        s_strobe_fall |-> ##[1:4] !bus_data_oe;
    endproperty
    property p_read_stable;
        bus_data_oe && $past(bus_data_oe) && $past(bus_data_oe, 2)
            |-> $stable(bus_data_out);
    endproperty
    property p_steer_rise;
        $rose(steer_guard_pin) |-> hi_cnt >= GUARD_PRESENT_CYCLES;
    endproperty
    property p_steer_fall;
        $fell(steer_guard_pin) |-> lo_cnt >= GUARD_ABSENT_CYCLES;
    endproperty
    property p_code_cause;
        $changed(tone_drive.code) |-> !$past(bus_read, 4)
            && $past(register_select_line, 4) == REG_DATA;
    endproperty
    property p_tone_cause;
        $rose(tone_drive.tone_on) |-> !$past(bus_read, 4);
    endproperty
    property p_open_drain;
        request_progress_pin_out == 1'b0;
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("data bus driven without a read");
    a_oe_release: assert property (p_oe_release)
        else $error("data bus still driven after access");
    a_read_stable: assert property (p_read_stable)
        else $error("read data moved during access");
    a_steer_rise: assert property (p_steer_rise)
        else $error("steering rose before guard time");
    a_steer_fall: assert property (p_steer_fall)
        else $error("steering fell before guard time");
    a_code_cause: assert property (p_code_cause)
        else $error("tone code changed without data write");
    a_tone_cause: assert property (p_tone_cause)
        else $error("tone started without a write");
    a_open_drain: assert property (p_open_drain)
        else $error("request pin driven high");
endmodule // dtmf_port_monitor

bind dtmf_transceiver_host_port dtmf_port_monitor #(
    .GUARD_PRESENT_CYCLES(GUARD_PRESENT_CYCLES),
    .GUARD_ABSENT_CYCLES(GUARD_ABSENT_CYCLES)
) dtmf_port_monitor_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus_cs_n(bus_cs_n),
    .bus_strobe(bus_strobe), .bus_read(bus_read),
    .register_select_line(register_select_line),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
    .early_steer_out(early_steer_out), .steer_guard_pin(steer_guard_pin),
    .request_progress_pin_out(request_progress_pin_out),
    .tone_drive(tone_drive)
);

// [dv/host_bus_model.sv]
// host processor model driving the register port pins
`timescale 1ns/100ps
module host_bus_model (
    input wire logic clk_sys,
    input wire logic [3:0] bus_data_out,
    output logic bus_cs_n,
    output logic bus_strobe,
    output logic bus_read,
    output logic register_select_line,
    output logic [3:0] bus_data_in
);
    // ==========
    // idle pins: deselected
    initial begin
        bus_cs_n = 1'b1;
        bus_strobe = 1'b0;
        bus_read = 1'b1;
        register_select_line = 1'b0;
        bus_data_in = 4'h5;
    end
    // one access: strobe high 5 cycles, low 7, pins held over the fall
    task automatic access(input logic rs, input logic rd,
        input logic [3:0] wd, output logic [3:0] rdat);
        bus_cs_n <= 1'b0;
        bus_read <= rd;
        register_select_line <= rs;
        bus_data_in <= rd ? ~bus_data_in : wd;
        bus_strobe <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rdat = bus_data_out;
        bus_strobe <= 1'b0;
        repeat (6) @(posedge clk_sys);
        bus_cs_n <= 1'b1;
        bus_data_in <= ~bus_data_in; // released lines show no stale value
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic rs, input logic [3:0] d);
        logic [3:0] dummy;
        access(rs, 1'b0, d, dummy);
    endtask
    task automatic rd(input logic rs, output logic [3:0] r);
        access(rs, 1'b1, 4'h0, r);
    endtask
    // start-up sequence that sets both control words and clears status
    task automatic soft_reset();
        logic [3:0] r;
        rd(1'b1, r);
        wr(1'b1, 4'h0);
        wr(1'b1, 4'h8);
        wr(1'b1, 4'h0);
        rd(1'b1, r);
    endtask
endmodule // host_bus_model

// [dv/dtmf_transceiver_host_port_tb.sv]
// self-checking bench of the tone transceiver host port
`timescale 1ns/100ps
module dtmf_transceiver_host_port_tb
    import dtmf_port_pkg::*;
;
    localparam int BURST_D = 50; // shortened dtmf burst
    localparam int BURST_C = 100; // shortened call progress burst
    localparam int GUARD = 20; // shortened guard times
    logic clk_sys;
    logic arst_n;
    logic bus_cs_n, bus_strobe, bus_read, register_select_line;
    logic [3:0] bus_data_in, bus_data_out, detect_code, r;
    logic bus_data_oe, early_steer_out, steer_guard_pin;
    logic request_progress_pin_out, request_progress_pin_oe;
    logic cp_tone_in; // call progress comparator stimulus
    tone_drive_s tone_drive;
    logic [15:0] on_cnt = '0; // current tone run
    logic [15:0] on_len = '0; // last finished tone run
    int fail_count = 0;
    int comparisons = 0;
    // ==========
    // clock, instances
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    dtmf_transceiver_host_port #(
        .BURST_DTMF_CYCLES(BURST_D), .BURST_CP_CYCLES(BURST_C),
        .GUARD_PRESENT_CYCLES(GUARD), .GUARD_ABSENT_CYCLES(GUARD)
    ) dtmf_transceiver_host_port_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .bus_cs_n(bus_cs_n),
        .bus_strobe(bus_strobe), .bus_read(bus_read),
        .register_select_line(register_select_line),
        .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
        .bus_data_oe(bus_data_oe), .early_steer_out(early_steer_out),
        .detect_code(detect_code), .cp_tone_in(cp_tone_in),
        .steer_guard_pin(steer_guard_pin),
        .request_progress_pin_out(request_progress_pin_out),
        .request_progress_pin_oe(request_progress_pin_oe),
        .tone_drive(tone_drive)
    );
    host_bus_model host_inst (
        .clk_sys(clk_sys), .bus_data_out(bus_data_out),
        .bus_cs_n(bus_cs_n), .bus_strobe(bus_strobe), .bus_read(bus_read),
        .register_select_line(register_select_line),
        .bus_data_in(bus_data_in)
    );
    // measures each tone run length
    always @(posedge clk_sys) begin
        on_cnt <= tone_drive.tone_on ? on_cnt + 16'h1 : 16'h0;
        if (!tone_drive.tone_on && on_cnt != 16'h0)
            on_len <= on_cnt;
    end
    // ==========
    // helpers
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic steer(input logic v, input int n);
        early_steer_out <= v;
        repeat (n) @(posedge clk_sys);
    endtask
    // one timed burst and pause, then transmit-ready checks
    task automatic burst(input logic [3:0] code, input int len,
        input logic pin);
        int n;
        host_inst.wr(REG_DATA, code);
        check("tone on", tone_drive.tone_on, 1'b1);
        check("tone code", tone_drive.code, code);
        n = 0;
        while (tone_drive.tone_on === 1'b1 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (len - 16) @(posedge clk_sys);
        check("burst length", on_len, 16'(len));
        host_inst.rd(REG_CTRL, r);
        check("ready in pause", r[STAT_TX_READY], 1'b0);
        repeat (12) @(posedge clk_sys);
        check("ready pin", request_progress_pin_oe, pin);
        host_inst.rd(REG_CTRL, r);
        check("ready after pause", r[STAT_TX_READY], 1'b1);
        host_inst.rd(REG_CTRL, r);
        check("ready cleared", r[STAT_TX_READY], 1'b0);
    endtask
    // ==========
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        tally_and_finish();
    end
    // ==========
    // main sequence
    initial begin
        arst_n = 1'b0;
        early_steer_out = 1'b0;
        detect_code = 4'h0;
        cp_tone_in = 1'b1;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        host_inst.soft_reset();
        host_inst.rd(REG_CTRL, r);
        check("idle status", r, 4'h8);
        host_inst.wr(REG_CTRL, 4'h4); // interrupts on, dtmf mode
        detect_code <= 4'h5;
        steer(1'b1, 10);
        steer(1'b0, 30);
        host_inst.rd(REG_DATA, r);
        check("short tone", r, 4'h0);
        check("no request", request_progress_pin_oe, 1'b0);
        steer(1'b1, 30);
        steer(1'b0, 5);
        steer(1'b1, 30);
        check("steering", steer_guard_pin, 1'b1);
        check("rx request", request_progress_pin_oe, 1'b1);
        host_inst.rd(REG_CTRL, r);
        check("rx status", r & 4'hc, 4'h4);
        check("request off", request_progress_pin_oe, 1'b0);
        host_inst.rd(REG_CTRL, r);
        check("valid cleared", r[STAT_RX_VALID], 1'b0);
        steer(1'b0, 40);
        check("steering off", steer_guard_pin, 1'b0);
        detect_code <= 4'ha;
        host_inst.rd(REG_DATA, r);
        check("rx code", r, 4'h5);
        host_inst.wr(REG_CTRL, 4'hd); // redirect armed, irq, tone
        host_inst.wr(REG_CTRL, 4'h0); // control b: burst timing on
        burst(4'h9, BURST_D, 1'b1);
        host_inst.wr(REG_CTRL, 4'h7); // call progress, irq, tone
        burst(4'h3, BURST_C, 1'b0);
        cp_tone_in <= 1'b0; // comparator low pulls the pin
        repeat (4) @(posedge clk_sys);
        check("cp pin low", request_progress_pin_oe, 1'b1);
        cp_tone_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("cp pin high", request_progress_pin_oe, 1'b0);
        steer(1'b1, 40);
        host_inst.rd(REG_CTRL, r);
        check("cp no valid", r[STAT_RX_VALID], 1'b0);
        steer(1'b0, 40);
        host_inst.rd(REG_DATA, r);
        check("cp no decode", r, 4'h5);
        host_inst.wr(REG_CTRL, 4'h8); // redirect armed, tone off
        host_inst.wr(REG_CTRL, 4'hd); // column, single, burst off
        host_inst.wr(REG_CTRL, 4'h1); // host-timed gate on
        check("gated on", tone_drive.tone_on, 1'b1);
        repeat (20) @(posedge clk_sys);
        host_inst.wr(REG_CTRL, 4'h0); // host-timed gate off
        check("gated off", tone_drive.tone_on, 1'b0);
        check("single kept", tone_drive.single, 1'b1);
        check("column kept", tone_drive.column_sel, 1'b1);
        host_inst.wr(REG_CTRL, 4'h8); // redirect armed, dtmf mode
        host_inst.wr(REG_CTRL, 4'hf); // control b: test mode on
        steer(1'b1, 30);
        check("test pin on", request_progress_pin_oe, 1'b1);
        steer(1'b0, 30);
        check("test pin off", request_progress_pin_oe, 1'b0);
        tally_and_finish();
    end
endmodule // dtmf_transceiver_host_port_tb
